/* File: rtl/adc_prog_map.svh */
/*
 * Holds the addresses, field positions, reset values and fixed test words of the program
 * register group. It assumes an 8-bit register port and a 16-bit output data word.
 */
// What this block does
// [R01] Mode field: run, power-down, standby, digital reset.
// [R02] Enabled mode pin high forces pin-function mode.
// [R03] Clock divides by divider field plus one.
// [R04] Test codes 0-4: off, midscale, full scales, checkerboard.
// [R05] Codes 5 and 6: long and short PRBS.
// [R06] Code 7 word toggle, code 8 user words.
// [R07] Codes 9-12: bit toggle, sync, one-high, mixed.
// [R08] Selected test data replaces converted samples.
// [R09] PRBS generators held reset while reset bits set.
// [R10] Signed eight-bit offset trim added, reset zero.
// [R11] Output format, output disable and output invert.
// [R12] Staged values become active on transfer bit.
// [R13] Clock bit 0 enables stabilizer, on after reset.
// [R14] User sequence: single/alternate, repeating/once.
`ifndef ADC_PROG_MAP_SVH
`define ADC_PROG_MAP_SVH

`define APR_ADDR_MODES 8'h08
`define APR_ADDR_CLOCK 8'h09
`define APR_ADDR_CLKDIV 8'h0B
`define APR_ADDR_TEST 8'h0D
`define APR_ADDR_OFFSET 8'h10
`define APR_ADDR_OUTMODE 8'h14
`define APR_ADDR_TRANSFER 8'hFF

`define APR_RST_MODES 8'h00
`define APR_RST_CLOCK 8'h01
`define APR_RST_CLKDIV 8'h00
`define APR_RST_TEST 8'h00
`define APR_RST_OFFSET 8'h00
`define APR_RST_OUTMODE 8'h00

`define APR_MODE_LSB 0
`define APR_PINFUNC_LSB 5
`define APR_PINEN_BIT 7
`define APR_DCS_BIT 0
`define APR_DIV_LSB 0
`define APR_TEST_LSB 0
`define APR_PN_SHORT_RST_BIT 4
`define APR_PN_LONG_RST_BIT 5
`define APR_USER_SEQ_LSB 6
`define APR_FMT_LSB 0
`define APR_INV_BIT 2
`define APR_DIS_BIT 4
`define APR_XFER_BIT 0

`define APR_WORD_MIDSCALE 16'h8000
`define APR_WORD_POS_FS 16'hFFFF
`define APR_WORD_NEG_FS 16'h0000
`define APR_WORD_CHECK_A 16'h5555
`define APR_WORD_CHECK_B 16'hAAAA
`define APR_WORD_BIT_ONE 16'h0001
`define APR_WORD_SYNC 16'h00FF
`define APR_WORD_MIXED 16'hA0F0
`define APR_PN9_SEED 9'h1FF
`define APR_PN23_SEED 23'h7FFFFF

`endif

/* File: rtl/adc_prog_pkg.sv */
/*
 * Types shared by the program register group and its pattern generator.
 * Leaves addresses, fields and reset values to adc_prog_map.svh; its enum values are its own.
 */
package adc_prog_pkg;
    typedef enum logic [1:0] {
        MODE_RUN = 2'h0,
        MODE_POWER_DOWN = 2'h1,
        MODE_STANDBY = 2'h2,
        MODE_DIGITAL_RESET = 2'h3
    } op_mode_t;

    typedef enum logic [3:0] {
        TP_OFF = 4'h0,
        TP_MIDSCALE = 4'h1,
        TP_POS_FULL_SCALE = 4'h2,
        TP_NEG_FULL_SCALE = 4'h3,
        TP_CHECKER = 4'h4,
        TP_LONG_PRBS = 4'h5,
        TP_SHORT_PRBS = 4'h6,
        TP_WORD_TOGGLE = 4'h7,
        TP_USER = 4'h8,
        TP_BIT_TOGGLE = 4'h9,
        TP_SYNC = 4'hA,
        TP_ONE_HIGH = 4'hB,
        TP_MIXED = 4'hC
    } test_code_t;

    // Gray-coded user pattern sequencer states.
    typedef enum logic [1:0] {
        SEQ_WORD1 = 2'h0,
        SEQ_WORD2 = 2'h1,
        SEQ_DONE = 2'h3
    } user_seq_t;

    typedef struct packed {
        logic [7:0] modes;
        logic [7:0] clock;
        logic [7:0] clkdiv;
        logic [7:0] test;
        logic [7:0] offset;
        logic [7:0] outmode;
    } prog_regs_t;
endpackage

/* File: rtl/test_pattern_gen.sv */
/*
 * Test word generator: fixed words, toggles, two PRBS generators and the user word sequencer.
 * Assumes advance_i pulses once per output sample and code_i is stable between samples.
 */
`timescale 1ns/100ps
`include "adc_prog_map.svh"
module test_pattern_gen #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Control
    input wire logic clear_i,
    input wire logic advance_i,
    input wire logic [3:0] code_i,
    input wire logic [1:0] user_seq_i,
    input wire logic pn_short_rst_i,
    input wire logic pn_long_rst_i,
    input wire logic [WIDTH-1:0] user_word1_i,
    input wire logic [WIDTH-1:0] user_word2_i,
    // Pattern word
    output logic [WIDTH-1:0] word_o
);
    logic [8:0] pn9_r, pn9_nxt;
    logic [22:0] pn23_r, pn23_nxt;
    logic phase_r, phase_nxt;
    logic [WIDTH-1:0] walk_r, walk_nxt;
    adc_prog_pkg::user_seq_t seq_r, seq_nxt;

    always_comb begin
        pn9_nxt = pn9_r;
        pn23_nxt = pn23_r;
        phase_nxt = phase_r;
        walk_nxt = walk_r;
        seq_nxt = seq_r;
        if (advance_i) begin
            pn9_nxt = {pn9_r[7:0], pn9_r[8] ^ pn9_r[4]};
            pn23_nxt = {pn23_r[21:0], pn23_r[22] ^ pn23_r[17]};
            phase_nxt = ~phase_r;
            walk_nxt = {walk_r[WIDTH-2:0], walk_r[WIDTH-1]};
            case (seq_r)
                adc_prog_pkg::SEQ_WORD1: begin
                    if (user_seq_i[0]) begin
                        seq_nxt = adc_prog_pkg::SEQ_WORD2;
                    end else if (user_seq_i[1]) begin
                        seq_nxt = adc_prog_pkg::SEQ_DONE;
                    end
                end
                adc_prog_pkg::SEQ_WORD2: begin
                    seq_nxt = user_seq_i[1] ? adc_prog_pkg::SEQ_DONE : adc_prog_pkg::SEQ_WORD1;
                end
                adc_prog_pkg::SEQ_DONE: seq_nxt = adc_prog_pkg::SEQ_DONE;
                default: seq_nxt = adc_prog_pkg::SEQ_WORD1;
            endcase
        end
        // Clear or the off code restarts the toggle phase, walking one and user sequence; clear also reseeds both PRBS, the off code does not.
        if (clear_i || code_i == adc_prog_pkg::TP_OFF) begin
            phase_nxt = 1'b0;
            walk_nxt = WIDTH'(1);
            seq_nxt = adc_prog_pkg::SEQ_WORD1;
        end
        if (clear_i || pn_short_rst_i) begin
            pn9_nxt = `APR_PN9_SEED; // [R09]
        end
        if (clear_i || pn_long_rst_i) begin
            pn23_nxt = `APR_PN23_SEED; // [R09]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pn9_r <= `APR_PN9_SEED;
            pn23_r <= `APR_PN23_SEED;
            phase_r <= 1'b0;
            walk_r <= WIDTH'(1);
            seq_r <= adc_prog_pkg::SEQ_WORD1;
        end else begin
            pn9_r <= pn9_nxt;
            pn23_r <= pn23_nxt;
            phase_r <= phase_nxt;
            walk_r <= walk_nxt;
            seq_r <= seq_nxt;
        end
    end

    always_comb begin
        case (code_i)
            adc_prog_pkg::TP_MIDSCALE: word_o = `APR_WORD_MIDSCALE; // [R04]
            adc_prog_pkg::TP_POS_FULL_SCALE: word_o = `APR_WORD_POS_FS; // [R04]
            adc_prog_pkg::TP_NEG_FULL_SCALE: word_o = `APR_WORD_NEG_FS; // [R04]
            adc_prog_pkg::TP_CHECKER: word_o = phase_r ? `APR_WORD_CHECK_B : `APR_WORD_CHECK_A; // [R04]
            adc_prog_pkg::TP_LONG_PRBS: word_o = pn23_r[WIDTH-1:0]; // [R05]
            adc_prog_pkg::TP_SHORT_PRBS: word_o = {pn9_r[6:0], pn9_r}; // [R05]
            adc_prog_pkg::TP_WORD_TOGGLE: word_o = {WIDTH{phase_r}}; // [R06]
            adc_prog_pkg::TP_USER: begin
                case (seq_r)
                    adc_prog_pkg::SEQ_WORD2: word_o = user_word2_i; // [R06] [R14]
                    adc_prog_pkg::SEQ_DONE: word_o = '0; // [R14]
                    default: word_o = user_word1_i; // [R06]
                endcase
            end
            adc_prog_pkg::TP_BIT_TOGGLE: word_o = phase_r ? '0 : `APR_WORD_BIT_ONE; // [R07]
            adc_prog_pkg::TP_SYNC: word_o = `APR_WORD_SYNC; // [R07]
            adc_prog_pkg::TP_ONE_HIGH: word_o = walk_r; // [R07]
            adc_prog_pkg::TP_MIXED: word_o = `APR_WORD_MIXED; // [R07]
            default: word_o = '0;
        endcase
    end

    pn_short_reset_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R09]
        pn_short_rst_i |=> pn9_r == `APR_PN9_SEED) else $error("short PRBS left reset");
    user_once_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R14]
        (advance_i && !clear_i && code_i == adc_prog_pkg::TP_USER && user_seq_i == 2'h2)
        |=> seq_r == adc_prog_pkg::SEQ_DONE) else $error("single-once did not stop");
endmodule

/* File: rtl/adc_program_register_bank.sv */
/*
 * Program register group: staged and active copies of the six program registers, the mode
 * decode, the input clock divider, and the output data path with trim, test words and format.
 * Assumes the serial port logic outside presents one decoded register access per strobe.
 */
`timescale 1ns/100ps
`include "adc_prog_map.svh"
module adc_program_register_bank #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Register port from the serial interface
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Pins and data
    input wire logic ext_mode_pin_i,
    input wire logic [WIDTH-1:0] sample_i,
    input wire logic [WIDTH-1:0] user_word1_i,
    input wire logic [WIDTH-1:0] user_word2_i,
    output logic [WIDTH-1:0] data_o,
    output logic data_oe_o,
    output logic sample_tick_o,
    // Operating state
    output logic duty_cycle_stabilizer_o,
    output logic power_down_o,
    output logic standby_o,
    output logic digital_reset_o,
    output logic test_active_o
);
    adc_prog_pkg::prog_regs_t staged_r, staged_nxt, active_r, active_nxt;
    logic [7:0] rdata_nxt;
    logic xfer;
    adc_prog_pkg::op_mode_t mode_eff;
    logic [2:0] div_cnt_r, div_cnt_nxt;
    logic tick_nxt;
    logic [WIDTH-1:0] pattern_word, data_nxt;
    logic signed [WIDTH+1:0] trimmed;
    logic [WIDTH-1:0] conv;
    logic test_on;

    assign xfer = reg_wr_i && reg_addr_i == `APR_ADDR_TRANSFER && reg_wdata_i[`APR_XFER_BIT];

    // Register group: writes land in the staged copy only.
    always_comb begin
        staged_nxt = staged_r;
        active_nxt = active_r;
        rdata_nxt = reg_rdata_o;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `APR_ADDR_MODES: staged_nxt.modes = reg_wdata_i;
                `APR_ADDR_CLOCK: staged_nxt.clock = reg_wdata_i;
                `APR_ADDR_CLKDIV: staged_nxt.clkdiv = reg_wdata_i;
                `APR_ADDR_TEST: staged_nxt.test = reg_wdata_i;
                `APR_ADDR_OFFSET: staged_nxt.offset = reg_wdata_i;
                `APR_ADDR_OUTMODE: staged_nxt.outmode = reg_wdata_i;
                default: staged_nxt = staged_r;
            endcase
        end
        // The transfer bit is self-clearing; it only copies staged into active.
        if (xfer) begin
            active_nxt = staged_r; // [R12]
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `APR_ADDR_MODES: rdata_nxt = staged_r.modes;
                `APR_ADDR_CLOCK: rdata_nxt = staged_r.clock;
                `APR_ADDR_CLKDIV: rdata_nxt = staged_r.clkdiv;
                `APR_ADDR_TEST: rdata_nxt = staged_r.test;
                `APR_ADDR_OFFSET: rdata_nxt = staged_r.offset;
                `APR_ADDR_OUTMODE: rdata_nxt = staged_r.outmode;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            staged_r <= {`APR_RST_MODES, `APR_RST_CLOCK, `APR_RST_CLKDIV,
                         `APR_RST_TEST, `APR_RST_OFFSET, `APR_RST_OUTMODE};
            active_r <= {`APR_RST_MODES, `APR_RST_CLOCK, `APR_RST_CLKDIV,
                         `APR_RST_TEST, `APR_RST_OFFSET, `APR_RST_OUTMODE};
            reg_rdata_o <= 8'h00;
        end else begin
            staged_r <= staged_nxt;
            active_r <= active_nxt;
            reg_rdata_o <= rdata_nxt;
        end
    end

    // The pin is sampled directly; it is taken to be synchronous to clk_i.
    always_comb begin
        if (active_r.modes[`APR_PINEN_BIT] && ext_mode_pin_i) begin
            mode_eff = adc_prog_pkg::op_mode_t'(active_r.modes[`APR_PINFUNC_LSB +: 2]); // [R02]
        end else begin
            mode_eff = adc_prog_pkg::op_mode_t'(active_r.modes[`APR_MODE_LSB +: 2]); // [R01]
        end
    end

    // Divider and sample path.
    assign test_on = active_r.test[`APR_TEST_LSB +: 4] != adc_prog_pkg::TP_OFF;
    assign trimmed = $signed({2'b00, sample_i})
                   + $signed({{(WIDTH-6){active_r.offset[7]}}, active_r.offset}); // [R10]

    always_comb begin
        logic [WIDTH-1:0] clamped;
        clamped = '0;
        if (trimmed < 0) begin
            clamped = '0;
        end else if (trimmed > $signed({2'b00, {WIDTH{1'b1}}})) begin
            clamped = '1;
        end else begin
            clamped = trimmed[WIDTH-1:0];
        end
        if (active_r.outmode[`APR_INV_BIT]) begin
            clamped = ~clamped; // [R11]
        end
        case (active_r.outmode[`APR_FMT_LSB +: 2])
            2'h1: conv = {~clamped[WIDTH-1], clamped[WIDTH-2:0]}; // [R11]
            2'h2: conv = clamped ^ (clamped >> 1); // [R11]
            default: conv = clamped; // [R11]
        endcase
    end

    always_comb begin
        div_cnt_nxt = div_cnt_r;
        tick_nxt = 1'b0;
        data_nxt = data_o;
        // Digital reset holds the divider and the output word at zero until the mode is left.
        if (mode_eff == adc_prog_pkg::MODE_DIGITAL_RESET) begin
            div_cnt_nxt = 3'h0; // [R01]
            data_nxt = '0;
        end else if (div_cnt_r >= active_r.clkdiv[`APR_DIV_LSB +: 3]) begin
            div_cnt_nxt = 3'h0; // [R03]
            tick_nxt = 1'b1; // [R03]
            data_nxt = test_on ? pattern_word : conv; // [R08]
        end else begin
            div_cnt_nxt = div_cnt_r + 3'h1; // [R03]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt_r <= 3'h0;
            sample_tick_o <= 1'b0;
            data_o <= '0;
            data_oe_o <= 1'b0;
            duty_cycle_stabilizer_o <= 1'b1;
            power_down_o <= 1'b0;
            standby_o <= 1'b0;
            digital_reset_o <= 1'b0;
            test_active_o <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            sample_tick_o <= tick_nxt;
            data_o <= data_nxt;
            data_oe_o <= !active_r.outmode[`APR_DIS_BIT]; // [R11]
            duty_cycle_stabilizer_o <= active_r.clock[`APR_DCS_BIT]; // [R13]
            power_down_o <= mode_eff == adc_prog_pkg::MODE_POWER_DOWN; // [R01]
            standby_o <= mode_eff == adc_prog_pkg::MODE_STANDBY; // [R01]
            digital_reset_o <= mode_eff == adc_prog_pkg::MODE_DIGITAL_RESET; // [R01]
            test_active_o <= test_on; // [R08]
        end
    end

    test_pattern_gen #(
        .WIDTH(WIDTH)
    ) u_pattern (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clear_i(mode_eff == adc_prog_pkg::MODE_DIGITAL_RESET),
        .advance_i(tick_nxt),
        .code_i(active_r.test[`APR_TEST_LSB +: 4]),
        .user_seq_i(active_r.test[`APR_USER_SEQ_LSB +: 2]),
        .pn_short_rst_i(active_r.test[`APR_PN_SHORT_RST_BIT]),
        .pn_long_rst_i(active_r.test[`APR_PN_LONG_RST_BIT]),
        .user_word1_i(user_word1_i),
        .user_word2_i(user_word2_i),
        .word_o(pattern_word)
    );

    transfer_commit_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R12]
        xfer |=> active_r == $past(staged_r)) else $error("transfer did not commit");
    staged_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R12]
        !xfer |=> $stable(active_r)) else $error("active changed without transfer");
    mode_decode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R01]
        (!active_r.modes[`APR_PINEN_BIT] && active_r.modes[1:0] == 2'h1)
        |=> power_down_o && !standby_o && !digital_reset_o) else $error("mode decode wrong");
    pin_override_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R02]
        (active_r.modes[`APR_PINEN_BIT] && ext_mode_pin_i && active_r.modes[6:5] == 2'h2)
        |=> standby_o) else $error("mode pin ignored");
    div_by_two_a: assert property (@(posedge clk_i) disable iff (!arst_n_i || xfer) // [R03]
        (sample_tick_o && active_r.clkdiv[2:0] == 3'h1 && !digital_reset_o)
        |=> !sample_tick_o ##1 sample_tick_o) else $error("divide by two wrong");
    test_replace_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R08]
        (tick_nxt && test_on) |=> data_o == $past(pattern_word)) else $error("test not shown");
    plain_sample_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R10]
        (tick_nxt && !test_on && active_r.offset == 8'h00 && active_r.outmode[2:0] == 3'h0)
        |=> data_o == $past(sample_i)) else $error("sample path altered");
    dcs_follow_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R13]
        ##1 duty_cycle_stabilizer_o == $past(active_r.clock[0])) else $error("stabilizer lag");
    out_disable_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R11]
        active_r.outmode[4] |=> !data_oe_o) else $error("outputs not disabled");
endmodule

/* File: dv/adc_host_model.sv */
/*
 * Host controller model that configures the program register group over its register port.
 * Assumes the bank takes one access per strobe on a rising edge and answers reads a cycle later.
 */
`timescale 1ns/100ps
module adc_host_model (
    // Clock
    input wire logic clk_i,
    // Register port toward the bank
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // Released lines show the inverse of the last value so stale data never looks valid.
    task automatic release_bus();
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        release_bus();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        d = reg_rdata_i;
        release_bus();
    endtask
    // Staged writes do nothing until the transfer bit is set.
    task automatic commit();
        write_reg(8'hFF, 8'h01);
    endtask
endmodule

/* File: dv/adc_program_register_bank_tb.sv */
/*
 * Self-checking testbench of the program register group, driven through the host model.
 * Assumes a 16-bit data path and the bank's register map at its default divider of one.
 */
`timescale 1ns/100ps
module adc_program_register_bank_tb;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wr, rd, pin, oe, tick, duty_cycle_stabilizer, pdn, stby, drst, tact;
    logic [7:0] addr, wdat, rdat;
    logic [15:0] smp = 16'h1234;
    logic [15:0] u1 = 16'hC3A5;
    logic [15:0] u2 = 16'h5A3C;
    logic [15:0] dat;
    int err_count = 0;
    int cmp_count = 0;

    initial pin = 1'b0;
    always #25 clk_i = ~clk_i;

    adc_host_model host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdat), .reg_rdata_i(rdat));
    adc_program_register_bank #(.WIDTH(16)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdat),
        .reg_rdata_o(rdat), .ext_mode_pin_i(pin), .sample_i(smp), .user_word1_i(u1),
        .user_word2_i(u2), .data_o(dat), .data_oe_o(oe), .sample_tick_o(tick),
        .duty_cycle_stabilizer_o(duty_cycle_stabilizer), .power_down_o(pdn), .standby_o(stby),
        .digital_reset_o(drst), .test_active_o(tact));

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Returns the word that comes out with the next sample tick.
    task automatic next_word(output logic [15:0] w);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (tick !== 1'b1 && n < 40);
        check("tick wait", 16'h0001, 16'(tick));
        w = dat;
    endtask
    task automatic set_reg(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d);
        host.commit();
        repeat (3) @(negedge clk_i);
    endtask

    task automatic test_reset();
        logic [7:0] ad [8] = '{8'h08, 8'h09, 8'h0B, 8'h0D, 8'h10, 8'h14, 8'h0A, 8'hFF};
        logic [7:0] rv [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] v;
        check("reset outputs", 16'h0020, 16'({duty_cycle_stabilizer, oe, drst, stby, pdn, tact}));
        host.write_reg(8'h0A, 8'h5A);
        for (int i = 0; i < 8; i++) begin
            host.read_reg(ad[i], v);
            check("register reset", 16'(rv[i]), 16'(v));
        end
        set_reg(8'h09, 8'h00);
        check("stabilizer", 16'h0000, 16'(duty_cycle_stabilizer));
        set_reg(8'h09, 8'h01);
        check("stabilizer", 16'h0001, 16'(duty_cycle_stabilizer));
    endtask
    task automatic test_staging();
        logic [7:0] v;
        logic [15:0] w;
        host.write_reg(8'h0D, 8'h02);
        host.read_reg(8'h0D, v);
        check("staged read", 16'h0002, 16'(v));
        next_word(w);
        next_word(w);
        check("before transfer", 16'h1234, w);
        host.commit();
        repeat (3) @(negedge clk_i);
        next_word(w);
        check("after transfer", 16'hFFFF, w);
    endtask
    task automatic test_codes();
        logic [3:0] cd [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'hA, 4'hC, 4'h8};
        logic [15:0] w0 [9] = '{16'h8000, 16'hFFFF, 16'h0000, 16'h5555, 16'h0000, 16'h0001,
            16'h00FF, 16'hA0F0, 16'hC3A5};
        logic [15:0] w1 [9] = '{16'h8000, 16'hFFFF, 16'h0000, 16'hAAAA, 16'hFFFF, 16'h0000,
            16'h00FF, 16'hA0F0, 16'hC3A5};
        logic [15:0] a, b;
        for (int i = 0; i < 9; i++) begin
            set_reg(8'h0D, {4'h0, cd[i]});
            next_word(a);
            next_word(b);
            check("pattern", (a === w1[i]) ? w1[i] : w0[i], a);
            check("pattern", (a === w1[i]) ? w0[i] : w1[i], b);
            check("test active", 16'h0001, 16'(tact));
        end
        set_reg(8'h0D, 8'h0B);
        next_word(a);
        next_word(b);
        check("walking one", {a[14:0], a[15]}, b);
        check("one bit high", 16'h0001, 16'($countones(a)));
    endtask
    task automatic test_prbs();
        logic [7:0] hold [2] = '{8'h16, 8'h25};
        logic [15:0] a, b;
        for (int i = 0; i < 2; i++) begin
            set_reg(8'h0D, hold[i]);
            next_word(a);
            next_word(b);
            check("prbs held", 16'hFFFF, a & b);
            set_reg(8'h0D, hold[i] & 8'h0F);
            next_word(a);
            next_word(b);
            check("prbs runs", 16'h0001, 16'(a !== b));
        end
    endtask
    task automatic test_user();
        logic [15:0] w [4];
        set_reg(8'h0D, 8'h48);
        next_word(w[0]);
        next_word(w[1]);
        check("alternate", (w[0] === u1) ? u2 : u1, w[1]);
        check("alternate pair", u1 ^ u2, w[0] ^ w[1]);
        set_reg(8'h0D, 8'h00);
        host.write_reg(8'h0D, 8'h88);
        host.commit();
        for (int i = 0; i < 4; i++) begin
            next_word(w[i]);
        end
        check("once word", u1, w[0]);
        check("once after", 16'h0000, w[3]);
        set_reg(8'h0D, 8'h00);
    endtask
    task automatic test_modes();
        logic [7:0] md [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'hC0, 8'hA0};
        logic [2:0] ex [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0, 3'h2, 3'h1};
        int n;
        pin = 1'b1;
        for (int i = 0; i < 7; i++) begin
            set_reg(8'h08, md[i]);
            check("mode outputs", 16'(ex[i]), 16'({drst, stby, pdn}));
            n = 0;
            repeat (10) begin
                @(negedge clk_i);
                n += int'(tick);
            end
            check("ticks", (i == 3) ? 16'h0000 : 16'h000A, 16'(n));
            // Digital reset must also hold the output word at zero, not just stop the ticks.
            if (i == 3) begin
                check("held word", 16'h0000, dat);
            end
        end
        pin = 1'b0;
        repeat (3) @(negedge clk_i);
        check("pin low", 16'h0000, 16'({drst, stby, pdn}));
        set_reg(8'h08, 8'h00);
    endtask
    task automatic test_divider();
        logic [15:0] w;
        int n;
        for (int d = 0; d < 8; d++) begin
            set_reg(8'h0B, 8'(d));
            next_word(w);
            n = 0;
            do begin
                @(negedge clk_i);
                n++;
            end while (tick !== 1'b1 && n < 20);
            check("tick period", 16'(d + 1), 16'(n));
        end
        set_reg(8'h0B, 8'h00);
    endtask
    task automatic test_trim_format();
        logic [15:0] sv [9] = '{16'h1234, 16'h1234, 16'hFFF0, 16'h0010, 16'h1234, 16'h1234,
            16'h1234, 16'h1234, 16'h1234};
        logic [7:0] ad [9] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h14, 8'h14, 8'h14, 8'h14};
        logic [7:0] vl [9] = '{8'h7F, 8'h80, 8'h7F, 8'h80, 8'h00, 8'h04, 8'h01, 8'h05, 8'h02};
        logic [15:0] ex [9] = '{16'h12B3, 16'h11B4, 16'hFFFF, 16'h0000, 16'h1234, 16'hEDCB,
            16'h9234, 16'h6DCB, 16'h1B2E};
        logic [15:0] w;
        // The last entry selects the Gray format, which no other scenario reaches.
        for (int i = 0; i < 9; i++) begin
            smp = sv[i];
            set_reg(ad[i], vl[i]);
            next_word(w);
            check("output word", ex[i], w);
        end
        set_reg(8'h14, 8'h10);
        check("output enable", 16'h0000, 16'(oe));
        set_reg(8'h14, 8'h00);
        check("output enable", 16'h0001, 16'(oe));
    endtask

    initial begin
        repeat (8) @(negedge clk_i);
        arst_n_i = 1'b1;
        test_reset();
        test_staging();
        test_codes();
        test_prbs();
        test_user();
        test_modes();
        test_divider();
        test_trim_format();
        end_sim();
    end
    // The whole sequence needs under a thousand cycles; twenty thousand means a hang.
    initial begin
        #(50 * 20000);
        err_count++;
        end_sim();
    end
endmodule
